// ---- hdl/lpc_pkg.sv ----
// constants for the lcd power, display-enable and clock-source control block
// assumes command bytes arrive whole from the serial front end as one-cycle strobes

package lpc_pkg;

   // ----------------------------------------------------------------
   // clock and oscillator timing
   // ----------------------------------------------------------------
   localparam int unsigned REF_CLK_HZ     = 125_000_000;
   localparam int unsigned OSC_FREQ_HZ    = 230_000;
   // longest period at the oscillator rate, rounded down
   localparam int unsigned OSC_DIV_CYCLES = REF_CLK_HZ / OSC_FREQ_HZ;
   localparam int unsigned OSC_CNT_W      = 10;

   // intermediate prescale factor and frame divide
   localparam int unsigned PRESCALE_Q     = 24;
   localparam int unsigned PRESCALE_HALF  = PRESCALE_Q / 2;
   localparam int unsigned FRAME_DIV      = 48;
   localparam int unsigned DIV_CNT_W      = 6;

   // ----------------------------------------------------------------
   // command decoding
   // ----------------------------------------------------------------
   localparam logic [4:0] CLK_SETUP_PATTERN  = 5'h03;
   localparam logic [3:0] MODE_SETUP_PATTERN = 4'h5;

   // clock-setup field positions
   localparam int unsigned EXT_RATE_BIT   = 2;
   localparam int unsigned PIN_OE_BIT     = 1;
   localparam int unsigned SRC_SEL_BIT    = 0;
   // mode-setup field positions
   localparam int unsigned LOW_POWER_POS  = 1;
   localparam int unsigned DISP_ON_POS    = 0;

   // reset values
   localparam logic RST_EXT_RATE   = 1'b0;
   localparam logic RST_PIN_OE     = 1'b0;
   localparam logic RST_SRC_SEL    = 1'b0;
   localparam logic RST_LOW_POWER  = 1'b0;
   localparam logic RST_DISP_ON    = 1'b0;

   // lcd output widths
   localparam int unsigned NUM_BACKPLANES = 8;
   localparam int unsigned NUM_SEGMENTS   = 40;

   // source in use by the timing chain
   typedef enum logic {LPC_SRC_INTERNAL, LPC_SRC_EXTERNAL} lpc_src_t;

endpackage

// ---- hdl/lpc_power_clock_control.sv ----
// power-down, display gating and clock-source control for the lcd driver
// assumes command bytes and the clock pin input are synchronous to ref_clk

`timescale 1ns/1ps

module lpc_power_clock_control
(
   // clock and reset
   input  wire logic                                  ref_clk,
   input  wire logic                                  reset,
   // command bytes from the serial front end
   input  wire logic                                  cmd_valid,
   input  wire logic [7:0]                            cmd_byte,
   // raw lcd drive levels from the waveform generator
   input  wire logic [lpc_pkg::NUM_BACKPLANES-1:0]    backplane_raw,
   input  wire logic [lpc_pkg::NUM_SEGMENTS-1:0]      segment_raw,
   // gated lcd outputs
   output logic      [lpc_pkg::NUM_BACKPLANES-1:0]    backplane_out,
   output logic      [lpc_pkg::NUM_SEGMENTS-1:0]      segment_out,
   // shared clock pin
   input  wire logic                                  shared_clock_pin_in,
   output logic                                       shared_clock_pin_out,
   output logic                                       shared_clock_pin_oe,
   // timing enables to the lcd logic
   output logic                                       lcd_clk_tick,
   output logic                                       frame_tick,
   // status
   output logic                                       oscillator_running,
   output logic                                       display_active,
   output logic                                       low_power_bit,
   output logic                                       clock_source_select,
   output logic                                       clock_pin_output_enable,
   output logic                                       external_rate_select
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic                                low_power_q;
   logic                                disp_on_q;
   logic                                src_sel_q;
   logic                                pin_oe_q;
   logic                                ext_rate_q;
   logic                                is_clk_setup;
   logic                                is_mode_setup;
   logic                                osc_run;
   logic [lpc_pkg::OSC_CNT_W-1:0]       osc_cnt_q;
   logic                                osc_tick;
   logic                                pin_in_q;
   logic                                ext_edge;
   lpc_pkg::lpc_src_t                   active_src_q;
   lpc_pkg::lpc_src_t                   wanted_src;
   logic                                wanted_tick;
   logic                                raw_tick;
   logic                                prescale_bypass;
   logic [lpc_pkg::DIV_CNT_W-1:0]       pre_cnt_q;
   logic                                inter_tick;
   logic                                inter_level_q;
   logic [lpc_pkg::DIV_CNT_W-1:0]       frame_cnt_q;
   logic                                drive_enable;

   // wrap test used by both divider counters
   function automatic logic at_last(input logic [lpc_pkg::DIV_CNT_W-1:0] cnt,
                                    input int unsigned                   div);
      at_last = (cnt == lpc_pkg::DIV_CNT_W'(div - 1));
   endfunction

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   // fixed upper patterns identify the two commands handled here
   assign is_clk_setup  = cmd_valid && (cmd_byte[7:3] == lpc_pkg::CLK_SETUP_PATTERN);
   assign is_mode_setup = cmd_valid && (cmd_byte[7:4] == lpc_pkg::MODE_SETUP_PATTERN);

   // clock-setup bits held until rewritten or reset
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         ext_rate_q <= lpc_pkg::RST_EXT_RATE;
         pin_oe_q   <= lpc_pkg::RST_PIN_OE;
         src_sel_q  <= lpc_pkg::RST_SRC_SEL;
      end
      else if (is_clk_setup)
      begin
         ext_rate_q <= cmd_byte[lpc_pkg::EXT_RATE_BIT];
         pin_oe_q   <= cmd_byte[lpc_pkg::PIN_OE_BIT];
         src_sel_q  <= cmd_byte[lpc_pkg::SRC_SEL_BIT];
      end
   end

   // mode-setup bits held until rewritten or reset
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         low_power_q <= lpc_pkg::RST_LOW_POWER;
         disp_on_q   <= lpc_pkg::RST_DISP_ON;
      end
      else if (is_mode_setup)
      begin
         low_power_q <= cmd_byte[lpc_pkg::LOW_POWER_POS];
         disp_on_q   <= cmd_byte[lpc_pkg::DISP_ON_POS];
      end
   end

   // ----------------------------------------------------------------
   // internal oscillator
   // ----------------------------------------------------------------
   // stopped in power-down and whenever the external source is chosen
   assign osc_run = !low_power_q && !src_sel_q;

   // oscillator model: one tick per oscillator period
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         osc_cnt_q <= '0;
      else if (!osc_run)
         osc_cnt_q <= '0;
      else if (osc_cnt_q == lpc_pkg::OSC_CNT_W'(lpc_pkg::OSC_DIV_CYCLES - 1))
         osc_cnt_q <= '0;
      else
         osc_cnt_q <= osc_cnt_q + 1'b1;
   end

   assign osc_tick = osc_run &&
                     (osc_cnt_q == lpc_pkg::OSC_CNT_W'(lpc_pkg::OSC_DIV_CYCLES - 1));

   // ----------------------------------------------------------------
   // external clock input
   // ----------------------------------------------------------------
   // previous pin level for rising-edge detection
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         pin_in_q <= 1'b0;
      else
         pin_in_q <= shared_clock_pin_in;
   end

   // pin level ignored while powered down, floating is harmless
   assign ext_edge = src_sel_q && !low_power_q &&
                     shared_clock_pin_in && !pin_in_q;

   // ----------------------------------------------------------------
   // source switch-over
   // ----------------------------------------------------------------
   // hand over only on the new source's own edge, so no period is cut short
   assign wanted_src  = src_sel_q ? lpc_pkg::LPC_SRC_EXTERNAL : lpc_pkg::LPC_SRC_INTERNAL;
   assign wanted_tick = src_sel_q ? ext_edge : osc_tick;

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         active_src_q <= lpc_pkg::LPC_SRC_INTERNAL;
      else if (active_src_q != wanted_src && wanted_tick)
         active_src_q <= wanted_src;
   end

   // ticks pass only while the active source matches the wanted one
   assign raw_tick = (active_src_q == wanted_src) && wanted_tick;

   // ----------------------------------------------------------------
   // prescaler and frame divider
   // ----------------------------------------------------------------
   // low external rate skips the prescaler
   assign prescale_bypass = src_sel_q && !ext_rate_q;

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         pre_cnt_q <= '0;
      else if (prescale_bypass || active_src_q != wanted_src)
         pre_cnt_q <= '0;
      else if (raw_tick)
         pre_cnt_q <= at_last(pre_cnt_q, lpc_pkg::PRESCALE_Q) ?
                      '0 : pre_cnt_q + 1'b1;
   end

   assign inter_tick = prescale_bypass ? raw_tick :
                       (raw_tick && at_last(pre_cnt_q, lpc_pkg::PRESCALE_Q));

   // intermediate clock level, square wave at the prescaled rate while the internal oscillator runs, held low otherwise
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         inter_level_q <= 1'b0;
      else if (!osc_run)
         inter_level_q <= 1'b0;
      else if (raw_tick)
      begin
         if (at_last(pre_cnt_q, lpc_pkg::PRESCALE_HALF))
            inter_level_q <= 1'b1;
         else if (at_last(pre_cnt_q, lpc_pkg::PRESCALE_Q))
            inter_level_q <= 1'b0;
      end
   end

   // frame counter over intermediate ticks
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         frame_cnt_q <= '0;
      else if (active_src_q != wanted_src)
         frame_cnt_q <= '0;
      else if (inter_tick)
         frame_cnt_q <= at_last(frame_cnt_q, lpc_pkg::FRAME_DIV) ?
                        '0 : frame_cnt_q + 1'b1;
   end

   // registered timing enables
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         lcd_clk_tick <= 1'b0;
         frame_tick   <= 1'b0;
      end
      else
      begin
         lcd_clk_tick <= raw_tick;
         frame_tick   <= inter_tick && at_last(frame_cnt_q, lpc_pkg::FRAME_DIV);
      end
   end

   // ----------------------------------------------------------------
   // lcd output gating
   // ----------------------------------------------------------------
   // power-down or display off forces ground, no frame alignment
   assign drive_enable = disp_on_q && !low_power_q;

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         backplane_out <= '0;
         segment_out   <= '0;
      end
      else
      begin
         backplane_out <= drive_enable ? backplane_raw : '0;
         segment_out   <= drive_enable ? segment_raw : '0;
      end
   end

   // ----------------------------------------------------------------
   // shared clock pin
   // ----------------------------------------------------------------
   // driven only with internal source and output enabled; high in power-down
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         shared_clock_pin_oe  <= 1'b0;
         shared_clock_pin_out <= 1'b0;
      end
      else
      begin
         shared_clock_pin_oe  <= pin_oe_q && !src_sel_q;
         shared_clock_pin_out <= low_power_q ? 1'b1 : inter_level_q;
      end
   end

   // ----------------------------------------------------------------
   // status
   // ----------------------------------------------------------------
   assign oscillator_running      = osc_run;
   assign display_active          = drive_enable;
   assign low_power_bit           = low_power_q;
   assign clock_source_select     = src_sel_q;
   assign clock_pin_output_enable = pin_oe_q;
   assign external_rate_select    = ext_rate_q;

endmodule // lpc_power_clock_control

// ---- test/lpc_host_model.sv ----
// host model: command bytes and the external clock on the shared pin
// assumes the bench resolves the pin level from the block's enable
`timescale 1ns/1ps
module lpc_host_model
(
   // bench clock
   input wire logic   ref_clk,
   // command strobe and byte
   output logic       cmd_valid,
   output logic [7:0] cmd_byte,
   // level the host puts on the pin
   output logic       host_pin
);
   // idle bus, clock stopped low
   initial
   begin
      cmd_valid = 1'b0;
      cmd_byte  = 8'h00;
      host_pin  = 1'b0;
   end
   // one whole byte per strobe, byte scrambled when idle
   task automatic send(input logic [7:0] b);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_byte  = b;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      cmd_byte  = ~b;
   endtask
   // external clock, two cycles high, two low
   task automatic clocks(input int n);
      repeat (n)
      begin
         host_pin = 1'b1;
         repeat (2) @(negedge ref_clk);
         host_pin = 1'b0;
         repeat (2) @(negedge ref_clk);
      end
   endtask
   // floating pin seen as a level changing every cycle
   task automatic float_pin(input int n);
      repeat (n)
      begin
         host_pin = ~host_pin;
         @(negedge ref_clk);
      end
      host_pin = 1'b0;
   endtask
endmodule // lpc_host_model

// ---- test/lpc_power_clock_control_properties.sv ----
// assertions on the power, display-gating and clock-source control block
// assumes one clock domain, reset async active high, bound to the top module
`timescale 1ns/1ps
module lpc_power_clock_control_properties
(
   // clock and reset
   input wire logic                               ref_clk,
   input wire logic                               reset,
   // command bus, raw levels and pin
   input wire logic                               cmd_valid,
   input wire logic [7:0]                         cmd_byte,
   input wire logic [lpc_pkg::NUM_BACKPLANES-1:0] backplane_raw,
   input wire logic [lpc_pkg::NUM_SEGMENTS-1:0]   segment_raw,
   input wire logic                               shared_clock_pin_in,
   // outputs
   input wire logic [lpc_pkg::NUM_BACKPLANES-1:0] backplane_out,
   input wire logic [lpc_pkg::NUM_SEGMENTS-1:0]   segment_out,
   input wire logic                               shared_clock_pin_out,
   input wire logic                               shared_clock_pin_oe,
   input wire logic                               lcd_clk_tick,
   input wire logic                               oscillator_running,
   input wire logic                               display_active,
   input wire logic                               low_power_bit,
   input wire logic                               clock_source_select,
   input wire logic                               clock_pin_output_enable,
   input wire logic                               external_rate_select
);
   // pin history; the first external edge after a source change only hands over
   logic                                          pin_prev_q;
   logic                                          ext_seen_q;
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         pin_prev_q <= 1'b0;
         ext_seen_q <= 1'b0;
      end
      else
      begin
         pin_prev_q <= shared_clock_pin_in;
         if (!clock_source_select)
            ext_seen_q <= 1'b0;
         else if (!low_power_bit && shared_clock_pin_in && !pin_prev_q)
            ext_seen_q <= 1'b1;
      end
   end
   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_clk_decode: assert property (
      cmd_valid && cmd_byte[7:3] == 5'h03 |=> {external_rate_select, clock_pin_output_enable,
      clock_source_select} == $past(cmd_byte[2:0])) else $error("clock setup not taken");
   a_mode_decode: assert property (
      cmd_valid && cmd_byte[7:4] == 4'h5 |=> low_power_bit == $past(cmd_byte[1])
      && display_active == ($past(cmd_byte[0]) && !$past(cmd_byte[1])))
      else $error("mode setup not taken");
   a_setup_hold: assert property (
      !cmd_valid |=> $stable({low_power_bit, clock_source_select, clock_pin_output_enable,
      external_rate_select})) else $error("setup bits moved without a command");
   a_dark_outputs: assert property (
      !display_active |=> backplane_out == '0 && segment_out == '0)
      else $error("lcd outputs live while display off");
   a_pd_ground: assert property (
      low_power_bit |=> backplane_out == '0 && segment_out == '0 && shared_clock_pin_out)
      else $error("power-down outputs wrong");
   a_live_outputs: assert property (
      display_active |=> {backplane_out, segment_out} == $past({backplane_raw, segment_raw}))
      else $error("backplane does not follow raw level");
   a_pin_enable: assert property (
      shared_clock_pin_oe == $past(clock_pin_output_enable && !clock_source_select))
      else $error("clock pin enable wrong");
   a_reset_hiz: assert property (
      @(posedge ref_clk) disable iff (1'b0) reset |-> !shared_clock_pin_oe)
      else $error("clock pin driven in reset");
   a_pd_quiet: assert property (
      low_power_bit[*3] |-> !lcd_clk_tick && !oscillator_running)
      else $error("timing runs in power-down");
   a_ext_tick: assert property (
      ext_seen_q && clock_source_select && !low_power_bit && $rose(shared_clock_pin_in)
      |-> ##[1:2] lcd_clk_tick) else $error("external edge gave no tick");
   a_no_short: assert property (
      lcd_clk_tick |=> !lcd_clk_tick) else $error("shortened timing pulse");
endmodule // lpc_power_clock_control_properties

bind lpc_power_clock_control lpc_power_clock_control_properties
   lpc_power_clock_control_properties_inst (.*);

// ---- test/lpc_power_clock_control_tb.sv ----
// self-checking bench for the power, display-gating and clock-source block
// assumes the host model drives commands and the external clock
`timescale 1ns/1ps
module lpc_power_clock_control_tb;
   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   logic                               ref_clk, reset, cmd_valid, host_pin;
   logic [7:0]                         cmd_byte;
   logic [lpc_pkg::NUM_BACKPLANES-1:0] bp_raw, bp_out;
   logic [lpc_pkg::NUM_SEGMENTS-1:0]   seg_raw, seg_out;
   logic                               pin_out, pin_oe, tick, frame, osc_on, disp;
   logic                               lp, src, oe_bit, rate;
   wire logic                          pin_in;
   int                                 miscompares, num_checks, n_tick, n_frame;

   // pin level from whoever drives it
   assign pin_in = pin_oe ? pin_out : host_pin;

   lpc_power_clock_control lpc_power_clock_control_inst (.ref_clk(ref_clk), .reset(reset),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .backplane_raw(bp_raw),
      .segment_raw(seg_raw), .backplane_out(bp_out), .segment_out(seg_out),
      .shared_clock_pin_in(pin_in), .shared_clock_pin_out(pin_out),
      .shared_clock_pin_oe(pin_oe), .lcd_clk_tick(tick), .frame_tick(frame),
      .oscillator_running(osc_on), .display_active(disp), .low_power_bit(lp),
      .clock_source_select(src), .clock_pin_output_enable(oe_bit),
      .external_rate_select(rate));
   lpc_host_model lpc_host_model_inst (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .host_pin(host_pin));

   // clock, 8 ns period
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // count timing pulses
   always @(posedge ref_clk)
   begin
      if (tick === 1'b1)
         n_tick++;
      if (frame === 1'b1)
         n_frame++;
   end

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic settle;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic end_sim;
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_reset;
      check("pin oe", pin_oe, 1'b0);
      check("setup", {lp, src, oe_bit, rate}, 4'h0);
      check("lcd", {bp_out, seg_out}, 48'h0);
   endtask
   task automatic t_display;
      bp_raw  = 8'hA5;
      seg_raw = 40'h5AC3F01E96;
      lpc_host_model_inst.send(8'h51);
      settle;
      check("lcd on", {bp_out, seg_out}, {8'hA5, 40'h5AC3F01E96});
      bp_raw  = 8'h3C;
      seg_raw = 40'h0F1E2D3C4B;
      @(negedge ref_clk);
      check("lcd follow", {bp_out, seg_out}, {8'h3C, 40'h0F1E2D3C4B});
      lpc_host_model_inst.send(8'h53);
      settle;
      check("lcd pd", {bp_out, seg_out}, 48'h0);
      lpc_host_model_inst.send(8'h50);
      lpc_host_model_inst.send(8'hF0);
      lpc_host_model_inst.send(8'h13);
      settle;
      check("refused", {lp, src, oe_bit, rate, disp}, 5'h00);
      check("lcd off", {bp_out, seg_out}, 48'h0);
   endtask
   task automatic t_pin;
      int   n, r, k;
      logic p;
      lpc_host_model_inst.send(8'h1A);
      settle;
      check("pin oe on", pin_oe, 1'b1);
      n = 0;
      r = 0;
      k = 0;
      p = 1'b1;
      while (r < 2 && k < 40000)
      begin
         @(negedge ref_clk);
         k++;
         if (r == 1)
            n++;
         if (pin_out === 1'b1 && !p)
            r++;
         p = pin_out;
      end
      check("pin period", n, lpc_pkg::OSC_DIV_CYCLES * lpc_pkg::PRESCALE_Q);
      lpc_host_model_inst.send(8'h52);
      settle;
      check("pin pd", {pin_oe, pin_out, osc_on}, 3'h6);
      lpc_host_model_inst.send(8'h50);
   endtask
   task automatic t_ext;
      lpc_host_model_inst.send(8'h1B);
      settle;
      check("ext oe", pin_oe, 1'b0);
      lpc_host_model_inst.clocks(1);
      lpc_host_model_inst.send(8'h51);
      n_tick  = 0;
      n_frame = 0;
      lpc_host_model_inst.clocks(96);
      lpc_host_model_inst.send(8'h50);
      check("ext ticks", n_tick, 96);
      check("low frames", n_frame, 2);
      lpc_host_model_inst.send(8'h1F);
      n_frame = 0;
      lpc_host_model_inst.clocks(1152);
      check("high frames", n_frame, 1);
      lpc_host_model_inst.send(8'h52);
      n_tick = 0;
      lpc_host_model_inst.float_pin(40);
      check("pd ticks", n_tick, 0);
      lpc_host_model_inst.send(8'h50);
   endtask
   task automatic t_rerun;
      lpc_host_model_inst.send(8'h1A);
      lpc_host_model_inst.send(8'h51);
      settle;
      check("pre rst oe", pin_oe, 1'b1);
      check("pre rst lcd", {bp_out, seg_out}, {8'h3C, 40'h0F1E2D3C4B});
      reset = 1'b1;
      @(negedge ref_clk);
      check("in rst", {pin_oe, lp, src, oe_bit, rate, disp}, 6'h00);
      check("in rst lcd", {bp_out, seg_out}, 48'h0);
      reset = 1'b0;
      t_reset;
      lpc_host_model_inst.send(8'h52);
      settle;
      check("final pd", {lp, osc_on}, 2'h2);
   endtask

   // main sequence
   initial
   begin
      reset   = 1'b1;
      bp_raw  = 8'h00;
      seg_raw = 40'h0000000000;
      repeat (5) @(negedge ref_clk);
      reset = 1'b0;
      t_reset;
      t_display;
      t_pin;
      t_ext;
      t_rerun;
      end_sim;
   end
   // watchdog
   initial
   begin
      #(90000 * 8);
      miscompares++;
      end_sim;
   end
endmodule // lpc_power_clock_control_tb
